// *** core/swe_engine.sv ***
// Two-wire single-bit engine with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Foreign repeated start over our 1 loses
// - Pre-empted repeated start or blocked stop loses
// - Arbitration and SDA drive need transmit active
// - Data write, repeated start or stop command, or auto start sets transmit active
// - Start flag except at idle slave
// - Stop flag except at idle slave
// - Mastership on request with bus free
// - Stretch SCL low while any flag set
// - Idle command ignores bus until start
// - Clear bits clear flags; data access clears bit ready, data read also clears transmit active
// - Repeated start: release low, drive after high
// - Stop: drive low, release after high
// - Transmit bit reaches SDA only while SCL low
// - Timer preloads eight minus count at edges
// - Timing select picks count seven to four
// - Timeout follows timing select, 1023 to 1020
// - Disabled with run clear holds timer cleared
// - Run clear uses only low timer bits
// - Run set counts whole timer in frames
// - Attention is OR of four flags
// - Bit ready on each SCL rise unless idle
// - Receive bit captured on SCL rise
// - Timer carry resets interface, releases SCL
module swe_engine #(
  parameter int MC_DIV = swe_pkg::SWE_MC_DIV
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic [31:0]       hrdata,
  output var  logic              hreadyout,
  output var  logic              hresp,
  input  wire logic              scl_i,
  output var  logic              scl_o,
  output var  logic              scl_oe_n,
  input  wire logic              sda_i,
  output var  logic              sda_o,
  output var  logic              sda_oe_n,
  output var  swe_pkg::swe_stat_t status_o
);
  import swe_pkg::*;

  logic [1:0]           pin_s;
  logic                 scl_s;
  logic                 sda_s;
  logic                 scl_p;
  logic                 sda_p;
  swe_cfg_t             cfg_r;
  swe_flags_t           flags_r;
  logic                 xact_r;
  logic                 tx_bit_r;
  logic                 rx_r;
  logic                 master_r;
  logic                 busy_r;
  logic                 idle_r;
  logic                 rstart_pend_r;
  logic                 stop_pend_r;
  logic                 armed_r;
  logic                 stop_chk_r;
  logic [SWE_TMR_W-1:0] timer_r;
  logic [2:0]           mc_cnt_r;
  logic                 wr_pend_r;
  logic [7:0]           wr_addr_r;
  logic                 pin_lo_r;

  swe_sync #(.W(2)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({scl_i, sda_i}),
    .q     (pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

  logic enabled;
  logic active;
  logic stretch;
  assign enabled = cfg_r.slave_enable | cfg_r.master_request | master_r;
  assign active  = enabled & (master_r | ~idle_r);
  assign stretch = |flags_r;

  // Minimum time count from timing select
  function automatic logic [3:0] min_count(input logic [1:0] sel);
    case (sel)
      2'b10:   min_count = SWE_MIN_CNT_10;
      2'b01:   min_count = SWE_MIN_CNT_01;
      2'b00:   min_count = SWE_MIN_CNT_00;
      default: min_count = SWE_MIN_CNT_11;
    endcase
  endfunction : min_count

  logic [SWE_TMR_W-1:0] preload;
  logic                 min_ok;
  logic                 mc_tick;
  logic                 timeout;
  assign preload = SWE_MIN_DONE
                 - {6'h00, min_count({cfg_r.timing_select_hi, cfg_r.timing_select_lo})};
  // Stale count would pass on the edge cycle itself
  assign min_ok  = (timer_r >= SWE_MIN_DONE) & ~scl_rise & ~scl_fall;
  assign mc_tick = (mc_cnt_r == 3'(MC_DIV - 1));
  assign timeout = enabled & cfg_r.bus_timer_run & busy_r & mc_tick & (&timer_r);

  // AHB-Lite decode: zero wait, reads answered from address phase
  logic     addr_ph;
  logic     rd_data;
  logic     wr_cfg;
  logic     wr_data;
  swe_cmd_t cmd;
  assign addr_ph = hsel & htrans[1] & hready;
  assign rd_data = addr_ph & ~hwrite & (haddr[7:0] == SWE_DATA_OFS);
  assign wr_cfg  = wr_pend_r & (wr_addr_r == SWE_CFG_OFS);
  assign wr_data = wr_pend_r & (wr_addr_r == SWE_DATA_OFS);
  assign cmd     = (wr_pend_r & (wr_addr_r == SWE_CTRL_OFS)) ? swe_cmd_t'(hwdata[7:0])
                                                             : swe_cmd_t'(8'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ph & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  logic arb_set;
  logic auto_start;
  logic drive_start;
  logic release_stop;
  assign arb_set = xact_r & (
      (scl_rise & tx_bit_r & ~sda_s & sda_oe_n)
    | (start_det & tx_bit_r & ~rstart_pend_r & sda_oe_n)
    | (master_r & rstart_pend_r & scl_fall)
    | (stop_chk_r & scl_fall));
  assign auto_start   = enabled & cfg_r.master_request & ~busy_r & ~rstart_pend_r
                      & ~stop_pend_r & ~stop_chk_r;
  assign drive_start  = rstart_pend_r & armed_r & xact_r & scl_s & min_ok;
  assign release_stop = stop_pend_r & armed_r & xact_r & scl_s & min_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= swe_cfg_t'(SWE_CFG_RST);
    end else if (wr_cfg) begin
      cfg_r <= swe_cfg_t'(hwdata[7:0] & 8'hcb);
    end
  end

  // Flags: hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= '0;
    end else if (timeout) begin
      flags_r <= '0;
    end else begin
      if (scl_rise & active)
        flags_r.bit_ready_flag <= 1'b1;
      else if (cmd.clear_bit_ready | wr_data | rd_data)
        flags_r.bit_ready_flag <= 1'b0;
      if (arb_set)
        flags_r.arbitration_lost_flag <= 1'b1;
      else if (cmd.clear_arbitration_lost)
        flags_r.arbitration_lost_flag <= 1'b0;
      if (start_det & active)
        flags_r.start_seen_flag <= 1'b1;
      else if (cmd.clear_start_seen)
        flags_r.start_seen_flag <= 1'b0;
      if (stop_det & active)
        flags_r.stop_seen_flag <= 1'b1;
      else if (cmd.clear_stop_seen)
        flags_r.stop_seen_flag <= 1'b0;
    end
  end

  // Next state shared with SDA so the pin drops with transmit active
  logic xact_nxt;
  always_comb begin
    xact_nxt = xact_r;
    if (timeout | arb_set)
      xact_nxt = 1'b0;
    else if (wr_data | cmd.send_repeated_start | cmd.send_stop_cmd | auto_start)
      xact_nxt = 1'b1;
    else if (rd_data | cmd.clear_transmit_active)
      xact_nxt = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      xact_r <= 1'b0;
    else
      xact_r <= xact_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tx_bit_r <= 1'b1;
    else if (cmd.send_stop_cmd)
      tx_bit_r <= 1'b0;
    else if (cmd.send_repeated_start | auto_start)
      tx_bit_r <= 1'b1;
    else if (wr_data)
      tx_bit_r <= hwdata[SWE_DATA_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rx_r <= 1'b0;
    else if (scl_rise)
      rx_r <= sda_s;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      master_r <= 1'b0;
    else if (timeout | arb_set)
      master_r <= 1'b0;
    else if (auto_start)
      master_r <= 1'b1;
    else if (stop_det & stop_chk_r & ~cfg_r.master_request)
      master_r <= 1'b0;
  end

  // Bus free after reset, timeout or stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      busy_r <= 1'b0;
    else if (timeout | stop_det)
      busy_r <= 1'b0;
    else if (start_det)
      busy_r <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      idle_r <= 1'b1;
    else if (start_det)
      idle_r <= 1'b0;
    else if (timeout | cmd.idle)
      idle_r <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rstart_pend_r <= 1'b0;
      stop_pend_r   <= 1'b0;
    end else if (timeout | arb_set) begin
      rstart_pend_r <= 1'b0;
      stop_pend_r   <= 1'b0;
    end else begin
      if (cmd.send_repeated_start | auto_start)
        rstart_pend_r <= 1'b1;
      else if (drive_start)
        rstart_pend_r <= 1'b0;
      if (cmd.send_stop_cmd)
        stop_pend_r <= 1'b1;
      else if (release_stop)
        stop_pend_r <= 1'b0;
    end
  end

  // A command given during SCL high waits for the next low phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      armed_r <= 1'b0;
    else if (auto_start)
      armed_r <= 1'b1;
    else if (cmd.send_repeated_start | cmd.send_stop_cmd)
      armed_r <= 1'b0;
    else if (~scl_s)
      armed_r <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      stop_chk_r <= 1'b0;
    else if (timeout | arb_set | stop_det)
      stop_chk_r <= 1'b0;
    else if (release_stop)
      stop_chk_r <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      sda_oe_n <= 1'b1;
    else if (~xact_nxt | ~xact_r)
      sda_oe_n <= 1'b1;
    else if (drive_start)
      sda_oe_n <= 1'b0;
    else if (release_stop)
      sda_oe_n <= 1'b1;
    else if (~scl_s)
      sda_oe_n <= tx_bit_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      scl_oe_n <= 1'b1;
    else if (timeout)
      scl_oe_n <= 1'b1;
    else if (master_r & busy_r & scl_s & scl_oe_n & min_ok & ~rstart_pend_r
             & ~stop_pend_r & ~stop_chk_r)
      scl_oe_n <= 1'b0;
    else if (~scl_s & active & stretch)
      scl_oe_n <= 1'b0;
    else if (~scl_oe_n & ~stretch & (~master_r | min_ok))
      scl_oe_n <= 1'b1;
  end

  // Full count only in frames; otherwise saturate at the minimum mark
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      timer_r <= '0;
    else if (~enabled | timeout)
      timer_r <= '0;
    else if (scl_rise | scl_fall | start_det | stop_det)
      timer_r <= preload;
    else if (mc_tick & cfg_r.bus_timer_run & busy_r)
      timer_r <= timer_r + 10'h001;
    else if (mc_tick & (timer_r < SWE_MIN_DONE))
      timer_r <= timer_r + 10'h001;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      mc_cnt_r <= 3'h0;
    else if (mc_tick)
      mc_cnt_r <= 3'h0;
    else
      mc_cnt_r <= mc_cnt_r + 3'h1;
  end

  swe_stat_t stat_now;
  always_comb begin
    stat_now.transmit_active       = xact_r;
    stat_now.receive_bit           = rx_r;
    stat_now.current_master        = master_r;
    stat_now.stop_seen_flag        = flags_r.stop_seen_flag;
    stat_now.start_seen_flag       = flags_r.start_seen_flag;
    stat_now.arbitration_lost_flag = flags_r.arbitration_lost_flag;
    stat_now.bit_ready_flag        = flags_r.bit_ready_flag;
    stat_now.attention_flag        = stretch;
  end

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      SWE_CTRL_OFS: rd_word[7:0] = stat_now;
      SWE_CFG_OFS:  rd_word[7:0] = cfg_r;
      SWE_DATA_OFS: rd_word[SWE_DATA_BIT] = rx_r;
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      status_o  <= '0;
      pin_lo_r  <= 1'b0;
    end else begin
      if (addr_ph & ~hwrite)
        hrdata <= rd_word;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      status_o  <= stat_now;
      pin_lo_r  <= 1'b0;
    end
  end
  assign scl_o = pin_lo_r;
  assign sda_o = pin_lo_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_start_due;
    drive_start && !timeout && !arb_set;
  endsequence
  sequence s_stop_due;
    release_stop && !timeout && !arb_set;
  endsequence

  start_drive_a: assert property (s_start_due |=> !sda_oe_n ##1 xact_r)
    else $error("repeated start did not drive SDA low");
  stop_release_a: assert property (s_stop_due |=> sda_oe_n && stop_chk_r)
    else $error("stop did not release SDA");
  sda_xact_a: assert property (!sda_oe_n |-> xact_r)
    else $error("SDA driven without transmit active");
  arb_clear_a: assert property (arb_set && !timeout |=> flags_r.arbitration_lost_flag
                                && !xact_r && !master_r)
    else $error("arbitration loss left transmit active");
  start_flag_a: assert property (start_det && active && !timeout
                                 |=> flags_r.start_seen_flag)
    else $error("start flag missed");
  idle_start_a: assert property (start_det && !active && !flags_r.start_seen_flag
                                 |=> !flags_r.start_seen_flag)
    else $error("start flag set at idle slave");
  stop_flag_a: assert property (stop_det && active && !timeout
                                |=> flags_r.stop_seen_flag)
    else $error("stop flag missed");
  stretch_hold_a: assert property (stretch && !scl_oe_n && !timeout
                                   |=> !scl_oe_n)
    else $error("SCL released while a flag is pending");
  ready_set_a: assert property (scl_rise && active && !timeout
                                |=> flags_r.bit_ready_flag)
    else $error("bit ready not set on SCL rise");
  rx_capture_a: assert property (scl_rise |=> rx_r == $past(sda_s))
    else $error("receive bit not captured");
  tx_apply_a: assert property (xact_r && xact_nxt && !scl_s && !tx_bit_r && !timeout && !arb_set
                               |=> !sda_oe_n)
    else $error("transmit bit zero not applied in SCL low");
  preload_a: assert property (enabled && !timeout && !arb_set && !wr_cfg
                              && (scl_rise || scl_fall) |=> timer_r == $past(preload))
    else $error("bus timer preload wrong");
  timer_hold_a: assert property (!enabled |=> timer_r == 10'h000 || enabled)
    else $error("bus timer runs while disabled");
  low_bits_a: assert property (enabled && !cfg_r.bus_timer_run && timer_r <= SWE_MIN_DONE
                               |=> timer_r <= SWE_MIN_DONE)
    else $error("high timer bits run with run clear");
  timeout_rst_a: assert property (timeout |=> flags_r == '0 && !master_r && !xact_r
                                  && scl_oe_n && !busy_r)
    else $error("timeout did not reset the interface");
endmodule : swe_engine
`default_nettype wire

// *** core/swe_pkg.sv ***
// Shared constants and types of the two-wire single-bit engine
package swe_pkg;
  localparam logic [7:0] SWE_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWE_CFG_OFS  = 8'h04;
  localparam logic [7:0] SWE_DATA_OFS = 8'h08;
  localparam int         SWE_DATA_BIT = 7;
  localparam logic [7:0] SWE_CFG_RST  = 8'h00;

  localparam int SWE_TMR_W  = 10;
  localparam int SWE_MC_DIV = 6;
  localparam logic [SWE_TMR_W-1:0] SWE_MIN_DONE = 10'h008;
  localparam logic [3:0] SWE_MIN_CNT_10 = 4'h7;
  localparam logic [3:0] SWE_MIN_CNT_01 = 4'h6;
  localparam logic [3:0] SWE_MIN_CNT_00 = 4'h5;
  localparam logic [3:0] SWE_MIN_CNT_11 = 4'h4;

  // Control register, write view
  typedef struct packed {
    logic send_stop_cmd;
    logic send_repeated_start;
    logic clear_stop_seen;
    logic clear_start_seen;
    logic clear_arbitration_lost;
    logic clear_bit_ready;
    logic idle;
    logic clear_transmit_active;
  } swe_cmd_t;

  // Control register, read view
  typedef struct packed {
    logic transmit_active;
    logic receive_bit;
    logic current_master;
    logic stop_seen_flag;
    logic start_seen_flag;
    logic arbitration_lost_flag;
    logic bit_ready_flag;
    logic attention_flag;
  } swe_stat_t;

  typedef struct packed {
    logic slave_enable;
    logic master_request;
    logic [1:0] rsvd_hi;
    logic bus_timer_run;
    logic rsvd_lo;
    logic timing_select_hi;
    logic timing_select_lo;
  } swe_cfg_t;

  typedef struct packed {
    logic stop_seen_flag;
    logic start_seen_flag;
    logic arbitration_lost_flag;
    logic bit_ready_flag;
  } swe_flags_t;
endpackage : swe_pkg

// *** core/swe_sync.sv ***
// Two-flop synchroniser for the bus pins
`timescale 1ns/1ps
`default_nettype none
module swe_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : swe_sync
`default_nettype wire

// *** dv/swe_bus_model.sv ***
// Other party on the two-wire bus, open-drain, released lines float high
`timescale 1ns/1ps
`default_nettype none
module swe_bus_model (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output var  logic scl_rel,
  output var  logic sda_rel
);
  localparam time HALF = 400ns;
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end
  // Bounded, so a stuck SCL cannot hang the run
  task automatic rise_scl();
    int n;
    n = 0;
    scl_rel = 1'b1;
    while (scl_w !== 1'b1 && n < 4000) begin
      #100ns;
      n++;
    end
  endtask : rise_scl
  task automatic start_c();
    sda_rel = 1'b1;
    #HALF;
    rise_scl();
    #HALF sda_rel = 1'b0;
    #HALF scl_rel = 1'b0;
  endtask : start_c
  // Data only moves while SCL is low
  task automatic bit_c(input logic v);
    scl_rel = 1'b0;
    #HALF sda_rel = v;
    #HALF;
    rise_scl();
    #HALF scl_rel = 1'b0;
  endtask : bit_c
  task automatic stop_c();
    scl_rel = 1'b0;
    #HALF sda_rel = 1'b0;
    #HALF;
    rise_scl();
    #HALF sda_rel = 1'b1;
    #HALF;
  endtask : stop_c
  task automatic idle_c();
    sda_rel = 1'b1;
    #HALF scl_rel = 1'b1;
    #HALF;
  endtask : idle_c
endmodule : swe_bus_model
`default_nettype wire

// *** dv/swe_tb.sv ***
// Self-checking bench for the two-wire single-bit engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import swe_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        scl_o;
  logic        scl_oe_n;
  logic        sda_o;
  logic        sda_oe_n;
  logic        m_scl;
  logic        m_sda;
  wire logic   scl_w;
  wire logic   sda_w;
  swe_stat_t   stat;
  int          bad_count;
  int          n_tests;
  int          n;
  time         t0;
  logic [31:0] rd;

  // Wires settle just off the clock edge, as a real pin would
  assign #1 scl_w = (scl_oe_n | scl_o) & m_scl;
  assign #1 sda_w = (sda_oe_n | sda_o) & m_sda;

  initial hclk = 1'b0;
  always #50ns hclk = ~hclk;

  swe_engine #(.MC_DIV(2)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .status_o(stat)
  );
  swe_bus_model m (.scl_w(scl_w), .sda_w(sda_w), .scl_rel(m_scl), .sda_rel(m_sda));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_hr();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      close_out();
    end
  endtask : wait_hr
  // One single word transfer; read data taken at the data-phase edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_hr();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_hr();
    rd = hrdata;
    chk("hresp", 8'h00, {7'h0, hresp});
  endtask : xfer
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    xfer(1'b0, a, 8'h00);
    chk(nm, exp, rd[7:0]);
  endtask : rchk
  task automatic cyc(input int c);
    repeat (c) @(posedge hclk);
  endtask : cyc

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = '0;
    bad_count = 0;
    n_tests = 0;
    cyc(20);
    chk("pins rst", 8'h03, {4'h0, scl_o, sda_o, scl_oe_n, sda_oe_n});
    hresetn <= 1'b1;
    rchk(SWE_CFG_OFS, SWE_CFG_RST, "cfg rst");
    rchk(SWE_CTRL_OFS, 8'h00, "stat rst");
    rchk(8'h0c, 8'h00, "unmapped");
    xfer(1'b1, SWE_CFG_OFS, 8'h37);
    rchk(SWE_CFG_OFS, 8'h03, "cfg rw");
    $display("test registers done");
    xfer(1'b1, SWE_CFG_OFS, 8'h80);
    m.start_c();
    cyc(8);
    rchk(SWE_CTRL_OFS, 8'h00, "wake start");
    m.bit_c(1'b1);
    cyc(8);
    chk("scl stretch", 8'h00, {7'h0, scl_oe_n});
    rchk(SWE_CTRL_OFS, 8'h43, "bit ready");
    rchk(SWE_DATA_OFS, 8'h80, "rx data");
    cyc(4);
    chk("scl free", 8'h01, {7'h0, scl_oe_n});
    $display("test receive done");
    xfer(1'b1, SWE_DATA_OFS, 8'h00);
    cyc(4);
    chk("sda drive", 8'h00, {7'h0, sda_oe_n});
    m.bit_c(1'b1);
    cyc(8);
    rchk(SWE_CTRL_OFS, 8'h83, "tx zero");
    rchk(SWE_DATA_OFS, 8'h00, "rx zero");
    cyc(4);
    chk("sda free", 8'h01, {7'h0, sda_oe_n});
    // Sending a 1 while the other side pulls 0
    xfer(1'b1, SWE_DATA_OFS, 8'h80);
    m.bit_c(1'b0);
    cyc(8);
    rchk(SWE_CTRL_OFS, 8'h07, "arb lost");
    xfer(1'b1, SWE_CTRL_OFS, 8'h08);
    cyc(4);
    chk("scl held", 8'h00, {7'h0, scl_oe_n});
    rchk(SWE_CTRL_OFS, 8'h03, "arb clear");
    xfer(1'b1, SWE_CTRL_OFS, 8'h04);
    rchk(SWE_CTRL_OFS, 8'h00, "rdy clear");
    $display("test transmit done");
    m.stop_c();
    cyc(8);
    rchk(SWE_CTRL_OFS, 8'h13, "stop seen");
    xfer(1'b1, SWE_CTRL_OFS, 8'h24);
    rchk(SWE_CTRL_OFS, 8'h00, "stop clear");
    $display("test stop done");
    xfer(1'b1, SWE_CFG_OFS, 8'h8a);
    xfer(1'b1, SWE_CTRL_OFS, 8'h02);
    m.bit_c(1'b1);
    cyc(8);
    xfer(1'b0, SWE_CTRL_OFS, 8'h00);
    chk("idle bit", 8'h00, rd[7:0] & 8'h1f);
    m.start_c();
    cyc(8);
    xfer(1'b0, SWE_CTRL_OFS, 8'h00);
    chk("idle wake", 8'h00, rd[7:0] & 8'h08);
    m.bit_c(1'b0);
    t0 = $time;
    cyc(8);
    xfer(1'b0, SWE_CTRL_OFS, 8'h00);
    chk("frame bit", 8'h02, rd[7:0] & 8'h02);
    // Left unserviced: only the hung-bus timer may end the stretch
    cyc(1920);
    chk("pre tmo", 8'h01, {7'h0, stat.bit_ready_flag});
    n = 0;
    while (stat.bit_ready_flag !== 1'b0 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    n = int'(($time - t0) / 100ns);
    chk("tmo time", 8'h01, {7'h0, n >= 2040 && n <= 2060});
    chk("tmo scl", 8'h01, {7'h0, scl_oe_n});
    rchk(SWE_CTRL_OFS, 8'h00, "tmo state");
    $display("test timeout done");
    m.idle_c();
    xfer(1'b1, SWE_CFG_OFS, 8'hca);
    n = 0;
    while (stat.current_master !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk("master", 8'h01, {7'h0, stat.current_master});
    n = 0;
    while (sda_oe_n !== 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk("auto start", 8'h00, {7'h0, sda_oe_n});
    $display("test master done");
    // Master holds SCL low after its start, then gives the bus back
    n = 0;
    while (scl_oe_n !== 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk("master scl", 8'h00, {7'h0, scl_oe_n});
    xfer(1'b1, SWE_CFG_OFS, 8'h8a);
    xfer(1'b1, SWE_CTRL_OFS, 8'h94);
    cyc(3);
    chk("stop sda", 8'h00, {7'h0, sda_oe_n});
    n = 0;
    while (stat.current_master !== 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    chk("master off", 8'h00, {7'h0, stat.current_master});
    rchk(SWE_CTRL_OFS, 8'h93, "stop sent");
    xfer(1'b1, SWE_CTRL_OFS, 8'h35);
    rchk(SWE_CTRL_OFS, 8'h00, "xact clear");
    $display("test stop command done");
    close_out();
  end
endmodule : tb
`default_nettype wire
